// ---- src/sce_params.svh ----
`ifndef SCE_PARAMS_SVH
`define SCE_PARAMS_SVH

// ==========================================================
// command codes
`define SCE_CMD_WRITE_SCRATCH 8'h0F
`define SCE_CMD_READ_SCRATCH 8'hAA
`define SCE_CMD_COPY_SCRATCH 8'h55

// ==========================================================
// control byte and its fields
`define SCE_CTRL_ADDR 16'h0201
`define SCE_CTRL_RESET 8'h00
`define SCE_CTRL_RTC_LOCK_BIT 0
`define SCE_CTRL_INTERVAL_LOCK_BIT 1
`define SCE_CTRL_CYCLE_LOCK_BIT 2
`define SCE_CTRL_READ_ONLY_BIT 3
`define SCE_CTRL_CRYSTAL_RUN_BIT 4
`define SCE_CTRL_LINE_GATED_BIT 5
`define SCE_CTRL_MANUAL_HALT_BIT 6
`define SCE_CTRL_EDGE_DELAY_BIT 7
`define SCE_CTRL_LOCK_MSB 2
`define SCE_CTRL_GUARD_MSB 3
`define SCE_CTRL_FREE_LSB 4

// ==========================================================
// target address and end status layout, lock arming count
`define SCE_OFFSET_MSB 4
`define SCE_PAGE_LSB 5
`define SCE_SCRATCH_LAST 5'h1F
`define SCE_ADDR_RESET 8'h00
`define SCE_LOCK_SEQ_ARM 2'h2

// ==========================================================
// timing
`define SCE_CLK_PERIOD_NS 4
`define SCE_EDGE_LONG_DELAY_MS 123
`define SCE_EDGE_SHORT_DELAY_US 3500
`define SCE_COPY_TIME_NS 30000
`define SCE_EDGE_LONG_CYCLES (`SCE_EDGE_LONG_DELAY_MS * 1000000 / `SCE_CLK_PERIOD_NS)
`define SCE_EDGE_SHORT_CYCLES (`SCE_EDGE_SHORT_DELAY_US * 1000 / `SCE_CLK_PERIOD_NS)
`define SCE_COPY_CYCLES (`SCE_COPY_TIME_NS / `SCE_CLK_PERIOD_NS)

`endif

// ---- src/sce_pkg.sv ----
package sce_pkg;
	typedef logic [7:0] byte_t;
	typedef logic [15:0] addr_t;
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR_LOW,
		ST_ADDR_HIGH,
		ST_WRITE_DATA,
		ST_READ_SCRATCH,
		ST_AUTH,
		ST_COPYING,
		ST_COPY_DONE,
		ST_IGNORE
	} cmd_state_e;
endpackage

// ---- src/sce_scratch_mem.sv ----
`timescale 1ns/100ps
module sce_scratch_mem #(
	parameter int AW = 5,
	parameter int DW = 8
) (
	input wire logic clk_i,
	input wire logic we_i,
	input wire logic [AW-1:0] waddr_i,
	input wire logic [DW-1:0] wdata_i,
	input wire logic [AW-1:0] raddr_i,
	output logic [DW-1:0] rdata_o
);
	// ==========================================================
	// storage, read data registered
	logic [DW-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge clk_i)
	begin
		if (we_i)
		begin
			mem[waddr_i] <= wdata_i;
		end
	end

	always_ff @(posedge clk_i)
	begin
		rdata_o <= mem[raddr_i];
	end
endmodule

// ---- src/sce_line_qualifier.sv ----
`timescale 1ns/100ps
module sce_line_qualifier #(
	parameter int unsigned LONG_CYCLES = 30750000,
	parameter int unsigned SHORT_CYCLES = 875000
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic line_i,
	input wire logic long_sel_i,
	output logic qual_o,
	output logic fall_o
);
	// ==========================================================
	// a change is accepted only after it held for the full delay
	logic [31:0] cnt_reg;
	logic [31:0] limit;

	assign limit = long_sel_i ? 32'(LONG_CYCLES) : 32'(SHORT_CYCLES);

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cnt_reg <= 32'h0;
			qual_o <= 1'b0;
			fall_o <= 1'b0;
		end
		else
		begin
			fall_o <= 1'b0;
			if (line_i == qual_o)
			begin
				cnt_reg <= 32'h0;
			end
			else if (cnt_reg + 32'h1 >= limit)
			begin
				cnt_reg <= 32'h0;
				qual_o <= line_i;
				fall_o <= ~line_i;
			end
			else
			begin
				cnt_reg <= cnt_reg + 32'h1;
			end
		end
	end
endmodule

// ---- src/scratchpad_copy_engine.sv ----
`timescale 1ns/100ps
`include "sce_params.svh"
module scratchpad_copy_engine #(
	parameter int unsigned LONG_DELAY_CYCLES = `SCE_EDGE_LONG_CYCLES,
	parameter int unsigned SHORT_DELAY_CYCLES = `SCE_EDGE_SHORT_CYCLES,
	parameter int unsigned COPY_CYCLES = `SCE_COPY_CYCLES
) (
	input wire logic CLK_SYS_I,
	input wire logic RST_N_I,
	input wire logic PORT_RESET_N_I,
	input wire sce_pkg::byte_t RX_BYTE_I,
	input wire logic RX_VALID_I,
	input wire logic RX_PARTIAL_I,
	input wire logic TX_REQ_I,
	output sce_pkg::byte_t TX_BYTE_O,
	output logic TX_VALID_O,
	output logic COPY_BUSY_O,
	output logic MEM_WR_EN_O,
	output sce_pkg::addr_t MEM_ADDR_O,
	output sce_pkg::byte_t MEM_WR_DATA_O,
	input wire logic LINE_I,
	input wire logic ALARM_RTC_I,
	input wire logic ALARM_INTERVAL_I,
	input wire logic ALARM_CYCLE_I,
	output sce_pkg::byte_t CONTROL_O,
	output sce_pkg::addr_t TARGET_ADDR_O,
	output sce_pkg::byte_t END_STATUS_O,
	output logic EXPIRED_O,
	output logic ROM_ONLY_O,
	output logic CRYSTAL_RUN_O,
	output logic TIMER_COUNT_EN_O,
	output logic CYCLE_COUNT_INC_O
);
	import sce_pkg::*;

	// ==========================================================
	// declarations
	cmd_state_e state_reg;
	byte_t target_addr_low_reg;
	byte_t target_addr_high_reg;
	byte_t ctrl_reg;
	logic [4:0] ending_offset_reg;
	logic partial_byte_flag_reg;
	logic overflow_flag_reg;
	logic auth_accepted_flag_reg;
	logic [4:0] wr_pos_reg;
	logic full_reg;
	logic [1:0] idx_reg;
	logic auth_bad_reg;
	logic [5:0] rd_pos_reg;
	logic [4:0] cp_pos_reg;
	logic cp_phase_reg;
	logic cp_bytes_done_reg;
	logic cp_covered_reg;
	logic [31:0] cp_timer_reg;
	logic [1:0] lock_seq_reg;
	logic expired_reg;
	byte_t sp_rdata;
	logic [4:0] sp_raddr;
	logic sp_we;
	logic rx_take;
	logic cmd_take;
	logic auth_last;
	logic auth_ok;
	logic cp_step;
	logic cp_finish;
	logic line_qual;
	logic line_fall;
	addr_t cp_addr;

	// ==========================================================
	// decoding shared by several processes
	function automatic byte_t status_byte(input logic aa, input logic ovf, input logic pf, input logic [4:0] e);
		return {aa, ovf, pf, e};
	endfunction

	function automatic logic any_lock(input byte_t c);
		return |c[`SCE_CTRL_LOCK_MSB:`SCE_CTRL_RTC_LOCK_BIT];
	endfunction

	function automatic byte_t auth_expect(input logic [1:0] i, input byte_t lo, input byte_t hi, input byte_t es);
		byte_t r;
		r = es;
		if (i == 2'h0)
		begin
			r = lo;
		end
		else if (i == 2'h1)
		begin
			r = hi;
		end
		return r;
	endfunction

	// a ctrl byte arriving by copy; guarded bits freeze once locked, locks need the armed sequence
	function automatic byte_t ctrl_merge(input byte_t old, input byte_t d, input logic armed);
		byte_t r;
		r = old;
		if (any_lock(old))
		begin
			r[7:`SCE_CTRL_FREE_LSB] = d[7:`SCE_CTRL_FREE_LSB];
		end
		else
		begin
			r[7:`SCE_CTRL_READ_ONLY_BIT] = d[7:`SCE_CTRL_READ_ONLY_BIT];
			if (armed)
			begin
				r[`SCE_CTRL_LOCK_MSB:0] = d[`SCE_CTRL_LOCK_MSB:0];
			end
		end
		return r;
	endfunction

	// ==========================================================
	// combinational strobes
	assign rx_take = RX_VALID_I & PORT_RESET_N_I;
	assign cmd_take = (state_reg == ST_IDLE) & rx_take;
	assign auth_last = (state_reg == ST_AUTH) & rx_take & (idx_reg == 2'h2);
	assign auth_ok = auth_last & ~auth_bad_reg & (RX_BYTE_I == auth_expect(idx_reg, target_addr_low_reg,
		target_addr_high_reg, END_STATUS_O));
	assign sp_we = (state_reg == ST_WRITE_DATA) & rx_take & ~full_reg & ~overflow_flag_reg;
	assign sp_raddr = (state_reg == ST_COPYING) ? cp_pos_reg : rd_pos_reg[4:0];
	assign cp_step = (state_reg == ST_COPYING) & ~cp_bytes_done_reg & cp_phase_reg;
	assign cp_finish = (state_reg == ST_COPYING) & cp_bytes_done_reg & (cp_timer_reg + 32'h1 >= 32'(COPY_CYCLES));
	assign cp_addr = {target_addr_high_reg, target_addr_low_reg[7:`SCE_PAGE_LSB], cp_pos_reg};

	// ==========================================================
	// command sequencing
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			state_reg <= ST_IDLE;
			idx_reg <= 2'h0;
			auth_bad_reg <= 1'b0;
		end
		else if (!PORT_RESET_N_I && state_reg != ST_COPYING)
		begin
			state_reg <= ST_IDLE;
		end
		else
		begin
			unique case (state_reg)
				ST_IDLE:
				begin
					idx_reg <= 2'h0;
					auth_bad_reg <= 1'b0;
					if (cmd_take)
					begin
						if (expired_reg && !ctrl_reg[`SCE_CTRL_READ_ONLY_BIT])
						begin
							state_reg <= ST_IGNORE;
						end
						else if (RX_BYTE_I == `SCE_CMD_READ_SCRATCH)
						begin
							state_reg <= ST_READ_SCRATCH;
						end
						else if (expired_reg)
						begin
							state_reg <= ST_IGNORE;
						end
						else if (RX_BYTE_I == `SCE_CMD_WRITE_SCRATCH)
						begin
							state_reg <= ST_ADDR_LOW;
						end
						else if (RX_BYTE_I == `SCE_CMD_COPY_SCRATCH)
						begin
							state_reg <= ST_AUTH;
						end
						else
						begin
							state_reg <= ST_IGNORE;
						end
					end
				end
				ST_ADDR_LOW:
				begin
					if (rx_take)
					begin
						state_reg <= ST_ADDR_HIGH;
					end
				end
				ST_ADDR_HIGH:
				begin
					if (rx_take)
					begin
						state_reg <= ST_WRITE_DATA;
					end
				end
				ST_READ_SCRATCH:
				begin
					if (TX_REQ_I && idx_reg != 2'h3)
					begin
						idx_reg <= idx_reg + 2'h1;
					end
				end
				ST_AUTH:
				begin
					if (rx_take)
					begin
						idx_reg <= idx_reg + 2'h1;
						if (RX_BYTE_I != auth_expect(idx_reg, target_addr_low_reg, target_addr_high_reg, END_STATUS_O))
						begin
							auth_bad_reg <= 1'b1;
						end
						if (auth_last)
						begin
							state_reg <= auth_ok ? ST_COPYING : ST_IGNORE;
						end
					end
				end
				ST_COPYING:
				begin
					if (cp_finish)
					begin
						state_reg <= ST_COPY_DONE;
					end
				end
				ST_WRITE_DATA, ST_COPY_DONE, ST_IGNORE:
				begin
					state_reg <= state_reg;
				end
			endcase
		end
	end

	// ==========================================================
	// target address and end status
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			target_addr_low_reg <= `SCE_ADDR_RESET;
			target_addr_high_reg <= `SCE_ADDR_RESET;
			ending_offset_reg <= 5'h0;
			partial_byte_flag_reg <= 1'b0;
			overflow_flag_reg <= 1'b0;
			auth_accepted_flag_reg <= 1'b0;
			wr_pos_reg <= 5'h0;
			full_reg <= 1'b0;
		end
		else if (cmd_take && !expired_reg && RX_BYTE_I == `SCE_CMD_WRITE_SCRATCH)
		begin
			auth_accepted_flag_reg <= 1'b0;
			overflow_flag_reg <= 1'b0;
			partial_byte_flag_reg <= 1'b0;
		end
		else if (state_reg == ST_ADDR_LOW && rx_take)
		begin
			target_addr_low_reg <= RX_BYTE_I;
		end
		else if (state_reg == ST_ADDR_HIGH && rx_take)
		begin
			target_addr_high_reg <= RX_BYTE_I;
			wr_pos_reg <= target_addr_low_reg[`SCE_OFFSET_MSB:0];
			ending_offset_reg <= target_addr_low_reg[`SCE_OFFSET_MSB:0];
			full_reg <= 1'b0;
		end
		else if (state_reg == ST_WRITE_DATA && rx_take)
		begin
			if (full_reg || overflow_flag_reg)
			begin
				overflow_flag_reg <= 1'b1;
			end
			else
			begin
				ending_offset_reg <= wr_pos_reg;
				full_reg <= (wr_pos_reg == `SCE_SCRATCH_LAST);
				wr_pos_reg <= (wr_pos_reg == `SCE_SCRATCH_LAST) ? wr_pos_reg : wr_pos_reg + 5'h1;
			end
		end
		else if (state_reg == ST_WRITE_DATA && !PORT_RESET_N_I && RX_PARTIAL_I)
		begin
			if (full_reg || overflow_flag_reg)
			begin
				overflow_flag_reg <= 1'b1;
			end
			else
			begin
				partial_byte_flag_reg <= 1'b1;
				ending_offset_reg <= wr_pos_reg;
			end
		end
		else if (auth_ok)
		begin
			auth_accepted_flag_reg <= 1'b1;
		end
	end

	// ==========================================================
	// scratchpad read-back and busy answers
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			rd_pos_reg <= 6'h0;
			TX_BYTE_O <= 8'h00;
			TX_VALID_O <= 1'b0;
		end
		else
		begin
			TX_VALID_O <= TX_REQ_I && (state_reg == ST_READ_SCRATCH || state_reg == ST_COPYING ||
				state_reg == ST_COPY_DONE);
			if (cmd_take)
			begin
				rd_pos_reg <= {1'b0, target_addr_low_reg[`SCE_OFFSET_MSB:0]};
			end
			if (TX_REQ_I && state_reg == ST_READ_SCRATCH)
			begin
				unique case (idx_reg)
					2'h0: TX_BYTE_O <= target_addr_low_reg;
					2'h1: TX_BYTE_O <= target_addr_high_reg;
					2'h2: TX_BYTE_O <= END_STATUS_O;
					2'h3:
					begin
						TX_BYTE_O <= rd_pos_reg[5] ? 8'hFF : sp_rdata;
						rd_pos_reg <= rd_pos_reg[5] ? rd_pos_reg : rd_pos_reg + 6'h1;
					end
				endcase
			end
			else if (TX_REQ_I && state_reg == ST_COPYING)
			begin
				TX_BYTE_O <= 8'hFF;
			end
			else if (TX_REQ_I && state_reg == ST_COPY_DONE)
			begin
				TX_BYTE_O <= 8'h00;
			end
		end
	end

	// ==========================================================
	// copy engine; one byte every two cycles, held busy until the nominal copy time since the start has passed
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			cp_pos_reg <= 5'h0;
			cp_phase_reg <= 1'b0;
			cp_bytes_done_reg <= 1'b0;
			cp_covered_reg <= 1'b0;
			cp_timer_reg <= 32'h0;
			MEM_WR_EN_O <= 1'b0;
			MEM_ADDR_O <= 16'h0000;
			MEM_WR_DATA_O <= 8'h00;
			COPY_BUSY_O <= 1'b0;
		end
		else
		begin
			MEM_WR_EN_O <= cp_step;
			COPY_BUSY_O <= (state_reg == ST_COPYING) && !cp_finish;
			if (auth_ok)
			begin
				cp_pos_reg <= target_addr_low_reg[`SCE_OFFSET_MSB:0];
				cp_phase_reg <= 1'b0;
				cp_bytes_done_reg <= 1'b0;
				cp_covered_reg <= 1'b0;
				cp_timer_reg <= 32'h0;
				COPY_BUSY_O <= 1'b1;
			end
			else if (state_reg == ST_COPYING)
			begin
				cp_timer_reg <= cp_timer_reg + 32'h1;
				cp_phase_reg <= ~cp_phase_reg;
				if (cp_step)
				begin
					MEM_ADDR_O <= cp_addr;
					MEM_WR_DATA_O <= sp_rdata;
					cp_covered_reg <= cp_covered_reg | (cp_addr == `SCE_CTRL_ADDR);
					cp_bytes_done_reg <= (cp_pos_reg == ending_offset_reg);
					cp_pos_reg <= cp_pos_reg + 5'h1;
				end
			end
		end
	end

	// ==========================================================
	// control byte and lock arming
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			ctrl_reg <= `SCE_CTRL_RESET;
			lock_seq_reg <= 2'h0;
		end
		else
		begin
			if (cp_step && cp_addr == `SCE_CTRL_ADDR)
			begin
				ctrl_reg <= ctrl_merge(ctrl_reg, sp_rdata, lock_seq_reg == `SCE_LOCK_SEQ_ARM);
			end
			if (cmd_take && RX_BYTE_I == `SCE_CMD_WRITE_SCRATCH)
			begin
				lock_seq_reg <= 2'h0;
			end
			else if (cp_finish)
			begin
				lock_seq_reg <= (cp_covered_reg && lock_seq_reg != `SCE_LOCK_SEQ_ARM) ? lock_seq_reg + 2'h1 : 2'h0;
			end
		end
	end

	// ==========================================================
	// expiration and timekeeping steering
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			expired_reg <= 1'b0;
			EXPIRED_O <= 1'b0;
			ROM_ONLY_O <= 1'b0;
			CRYSTAL_RUN_O <= 1'b0;
			TIMER_COUNT_EN_O <= 1'b0;
			CYCLE_COUNT_INC_O <= 1'b0;
			CONTROL_O <= `SCE_CTRL_RESET;
			TARGET_ADDR_O <= 16'h0000;
			END_STATUS_O <= 8'h00;
		end
		else
		begin
			// expiry is permanent until power-down; nothing in software may clear it
			expired_reg <= expired_reg | (ctrl_reg[`SCE_CTRL_RTC_LOCK_BIT] & ALARM_RTC_I) |
				(ctrl_reg[`SCE_CTRL_INTERVAL_LOCK_BIT] & ALARM_INTERVAL_I) |
				(ctrl_reg[`SCE_CTRL_CYCLE_LOCK_BIT] & ALARM_CYCLE_I);
			EXPIRED_O <= expired_reg;
			ROM_ONLY_O <= expired_reg & ~ctrl_reg[`SCE_CTRL_READ_ONLY_BIT];
			CRYSTAL_RUN_O <= ctrl_reg[`SCE_CTRL_CRYSTAL_RUN_BIT];
			TIMER_COUNT_EN_O <= ctrl_reg[`SCE_CTRL_CRYSTAL_RUN_BIT] & (ctrl_reg[`SCE_CTRL_LINE_GATED_BIT] ?
				line_qual : ~ctrl_reg[`SCE_CTRL_MANUAL_HALT_BIT]);
			CYCLE_COUNT_INC_O <= line_fall & ctrl_reg[`SCE_CTRL_CRYSTAL_RUN_BIT];
			CONTROL_O <= ctrl_reg;
			TARGET_ADDR_O <= {target_addr_high_reg, target_addr_low_reg};
			END_STATUS_O <= status_byte(auth_accepted_flag_reg, overflow_flag_reg, partial_byte_flag_reg,
				ending_offset_reg);
		end
	end

	// ==========================================================
	// instances
	sce_scratch_mem #(
		.AW(5),
		.DW(8)
	) u_mem (
		.clk_i(CLK_SYS_I),
		.we_i(sp_we),
		.waddr_i(wr_pos_reg),
		.wdata_i(RX_BYTE_I),
		.raddr_i(sp_raddr),
		.rdata_o(sp_rdata)
	);

	sce_line_qualifier #(
		.LONG_CYCLES(LONG_DELAY_CYCLES),
		.SHORT_CYCLES(SHORT_DELAY_CYCLES)
	) u_qual (
		.clk_i(CLK_SYS_I),
		.rst_n_i(RST_N_I),
		.line_i(LINE_I),
		.long_sel_i(ctrl_reg[`SCE_CTRL_EDGE_DELAY_BIT]),
		.qual_o(line_qual),
		.fall_o(line_fall)
	);
endmodule

// ---- test/scratchpad_copy_engine_checker.sv ----
`timescale 1ns/100ps
module scratchpad_copy_engine_checker #(
	parameter int unsigned LONG_DELAY_CYCLES = 40,
	parameter int unsigned SHORT_DELAY_CYCLES = 10,
	parameter int unsigned COPY_CYCLES = 20
) (
	input wire logic CLK_SYS_I,
	input wire logic RST_N_I,
	input wire logic TX_REQ_I,
	input wire sce_pkg::byte_t TX_BYTE_O,
	input wire logic TX_VALID_O,
	input wire logic COPY_BUSY_O,
	input wire logic MEM_WR_EN_O,
	input wire sce_pkg::addr_t MEM_ADDR_O,
	input wire sce_pkg::byte_t CONTROL_O,
	input wire sce_pkg::byte_t END_STATUS_O,
	input wire logic EXPIRED_O,
	input wire logic ROM_ONLY_O
);
	import sce_pkg::*;
	// ==========
	// sequences and properties
	default clocking cb @(posedge CLK_SYS_I);
	endclocking
	default disable iff (!RST_N_I);
	sequence copy_start_q;
		$rose(COPY_BUSY_O);
	endsequence
	sequence auth_flag_q;
		##[0:3] END_STATUS_O[7];
	endsequence
	tx_answer_cause_a: assert property (TX_VALID_O |-> $past(TX_REQ_I))
		else $error("answer without request");
	tx_one_cycle_a: assert property (TX_VALID_O |=> !TX_VALID_O)
		else $error("answer longer than a cycle");
	busy_ones_a: assert property (TX_VALID_O && COPY_BUSY_O && $past(COPY_BUSY_O, 2) |-> TX_BYTE_O == 8'hFF)
		else $error("busy answer not all ones");
	auth_after_copy_a: assert property (copy_start_q |-> auth_flag_q)
		else $error("accepted flag missing");
	busy_hold_a: assert property (copy_start_q |=> COPY_BUSY_O [*8]) else $error("copy ended early");
	write_in_copy_a: assert property (MEM_WR_EN_O |-> COPY_BUSY_O)
		else $error("memory write outside copy");
	copy_addr_step_a: assert property (MEM_WR_EN_O ##2 MEM_WR_EN_O |->
		MEM_ADDR_O == $past(MEM_ADDR_O, 2) + 16'h0001) else $error("copy address not consecutive");
	lock_freeze_a: assert property (CONTROL_O[2:0] != 3'h0 |=> CONTROL_O[3:0] == $past(CONTROL_O[3:0]))
		else $error("guarded control bits changed");
	expiry_cause_a: assert property ($rose(EXPIRED_O) |-> $past(CONTROL_O[2:0]) != 3'h0)
		else $error("expiry without lock");
	expiry_sticky_a: assert property (EXPIRED_O |=> EXPIRED_O) else $error("expiry dropped");
	rom_only_cause_a: assert property (ROM_ONLY_O |-> EXPIRED_O && !CONTROL_O[3])
		else $error("rom only wrongly set");
	rom_only_set_a: assert property (EXPIRED_O && !CONTROL_O[3] |=> ROM_ONLY_O)
		else $error("rom only not set");
endmodule
bind scratchpad_copy_engine scratchpad_copy_engine_checker #(
	.LONG_DELAY_CYCLES(LONG_DELAY_CYCLES),
	.SHORT_DELAY_CYCLES(SHORT_DELAY_CYCLES),
	.COPY_CYCLES(COPY_CYCLES)
) chk (
	.CLK_SYS_I(CLK_SYS_I),
	.RST_N_I(RST_N_I),
	.TX_REQ_I(TX_REQ_I),
	.TX_BYTE_O(TX_BYTE_O),
	.TX_VALID_O(TX_VALID_O),
	.COPY_BUSY_O(COPY_BUSY_O),
	.MEM_WR_EN_O(MEM_WR_EN_O),
	.MEM_ADDR_O(MEM_ADDR_O),
	.CONTROL_O(CONTROL_O),
	.END_STATUS_O(END_STATUS_O),
	.EXPIRED_O(EXPIRED_O),
	.ROM_ONLY_O(ROM_ONLY_O)
);

// ---- test/sce_host_model.sv ----
`timescale 1ns/100ps
module sce_host_model (
	input wire logic clk_i,
	input wire sce_pkg::byte_t tx_byte_i,
	input wire logic tx_valid_i,
	output logic port_reset_n_o,
	output sce_pkg::byte_t rx_byte_o,
	output logic rx_valid_o,
	output logic rx_partial_o,
	output logic tx_req_o
);
	import sce_pkg::*;
	// ==========
	// host side of the byte port
	initial
	begin
		port_reset_n_o = 1'b0;
		rx_byte_o = 8'h00;
		rx_valid_o = 1'b0;
		rx_partial_o = 1'b0;
		tx_req_o = 1'b0;
	end
	// released data bus shows the inverse so a stale byte never passes
	task automatic send_byte(input byte_t b);
		@(posedge clk_i);
		#1;
		rx_byte_o = b;
		rx_valid_o = 1'b1;
		@(posedge clk_i);
		#1;
		rx_valid_o = 1'b0;
		rx_byte_o = ~b;
	endtask
	task automatic start_cmd(input byte_t cmd);
		@(posedge clk_i);
		#1;
		port_reset_n_o = 1'b1;
		send_byte(cmd);
	endtask
	task automatic end_session(input logic partial);
		@(posedge clk_i);
		#1;
		port_reset_n_o = 1'b0;
		rx_partial_o = partial;
		repeat (2) @(posedge clk_i);
		#1;
		rx_partial_o = 1'b0;
	endtask
	task automatic read_byte(output byte_t b, output logic ok);
		@(posedge clk_i);
		#1;
		tx_req_o = 1'b1;
		@(posedge clk_i);
		#1;
		tx_req_o = 1'b0;
		ok = 1'b0;
		b = 8'hXX;
		for (int i = 0; i < 3 && !ok; i++)
		begin
			if (tx_valid_i === 1'b1)
			begin
				ok = 1'b1;
				b = tx_byte_i;
			end
			else
				@(posedge clk_i) #1;
		end
	endtask
endmodule

// ---- test/test_scratchpad_copy_engine.sv ----
`timescale 1ns/100ps
module test_scratchpad_copy_engine;
	import sce_pkg::*;
	typedef struct {addr_t a; int n; logic p; byte_t es; byte_t m;} row_s;
	logic clk, rst_n, port_reset_n, rx_valid, rx_partial, tx_req, tx_valid, copy_busy, mem_wr_en, line;
	logic alarm_rtc, alarm_int, alarm_cyc, expired, rom_only, crystal_run, timer_en, rok, cyc_inc;
	byte_t rx_byte, tx_byte, mem_wr_data, control, end_status, rb;
	addr_t mem_addr, target_addr;
	byte_t scr [32];
	addr_t wr_a [32];
	byte_t wr_d [32];
	int wr_n = 0;
	int fails = 0;
	int compares = 0;
	int cycles = 0;
	int inc_n = 0;
	// partial last row: ending offset of a partial byte is left open, flags only
	row_s rows [4] = '{'{16'h01E0, 32, 1'b0, 8'h1F, 8'hFF}, '{16'h0026, 2, 1'b0, 8'h07, 8'hFF},
		'{16'h003E, 3, 1'b1, 8'h5F, 8'hFF}, '{16'h0105, 1, 1'b1, 8'h20, 8'hE0}};
	// ==========
	// design and host
	scratchpad_copy_engine #(
		.LONG_DELAY_CYCLES(40),
		.SHORT_DELAY_CYCLES(10),
		.COPY_CYCLES(20)
	) uut (
		.CLK_SYS_I(clk),
		.RST_N_I(rst_n),
		.PORT_RESET_N_I(port_reset_n),
		.RX_BYTE_I(rx_byte),
		.RX_VALID_I(rx_valid),
		.RX_PARTIAL_I(rx_partial),
		.TX_REQ_I(tx_req),
		.TX_BYTE_O(tx_byte),
		.TX_VALID_O(tx_valid),
		.COPY_BUSY_O(copy_busy),
		.MEM_WR_EN_O(mem_wr_en),
		.MEM_ADDR_O(mem_addr),
		.MEM_WR_DATA_O(mem_wr_data),
		.LINE_I(line),
		.ALARM_RTC_I(alarm_rtc),
		.ALARM_INTERVAL_I(alarm_int),
		.ALARM_CYCLE_I(alarm_cyc),
		.CONTROL_O(control),
		.TARGET_ADDR_O(target_addr),
		.END_STATUS_O(end_status),
		.EXPIRED_O(expired),
		.ROM_ONLY_O(rom_only),
		.CRYSTAL_RUN_O(crystal_run),
		.TIMER_COUNT_EN_O(timer_en),
		.CYCLE_COUNT_INC_O(cyc_inc)
	);
	sce_host_model host (
		.clk_i(clk),
		.tx_byte_i(tx_byte),
		.tx_valid_i(tx_valid),
		.port_reset_n_o(port_reset_n),
		.rx_byte_o(rx_byte),
		.rx_valid_o(rx_valid),
		.rx_partial_o(rx_partial),
		.tx_req_o(tx_req)
	);
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk)
	begin
		if (mem_wr_en === 1'b1 && wr_n < 32)
		begin
			wr_a[wr_n] = mem_addr;
			wr_d[wr_n] = mem_wr_data;
			wr_n++;
		end
		if (cyc_inc === 1'b1)
			inc_n++;
		cycles++;
		if (cycles == 20000)
		begin
			fails++;
			tally_and_finish();
		end
	end
	// ==========
	// tasks
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp)
		begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic tally_and_finish();
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic do_reset();
		rst_n = 1'b0;
		repeat (6) @(posedge clk);
		#1;
		rst_n = 1'b1;
	endtask
	task automatic rd_exp(input string name, input byte_t exp, input byte_t m);
		byte_t b;
		logic ok;
		host.read_byte(b, ok);
		chk(name, 16'(exp & m), 16'(b & m));
	endtask
	task automatic write_session(input addr_t a, input int n, input logic p, input byte_t base);
		byte_t d;
		host.start_cmd(8'h0F);
		host.send_byte(a[7:0]);
		host.send_byte(a[15:8]);
		for (int i = 0; i < n; i++)
		begin
			d = base + 8'(i);
			host.send_byte(d);
			if (int'(a[4:0]) + i < 32)
				scr[int'(a[4:0]) + i] = d;
		end
		host.end_session(p);
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic read_check(input addr_t a, input byte_t es, input byte_t m);
		host.start_cmd(8'hAA);
		rd_exp("read low", a[7:0], 8'hFF);
		rd_exp("read high", a[15:8], 8'hFF);
		rd_exp("read status", es, m);
		for (int i = int'(a[4:0]); i < 32; i++)
			rd_exp("read data", scr[i], 8'hFF);
		rd_exp("read past end", 8'hFF, 8'hFF);
		host.end_session(1'b0);
	endtask
	task automatic copy_run(input byte_t lo, input byte_t hi, input byte_t es, input logic exp_ok, input logic drop);
		int k;
		wr_n = 0;
		host.start_cmd(8'h55);
		host.send_byte(lo);
		host.send_byte(hi);
		host.send_byte(es);
		k = 0;
		while (copy_busy !== 1'b1 && k < 6)
		begin
			@(posedge clk) #1;
			k++;
		end
		chk("copy busy", 16'(exp_ok), 16'(copy_busy));
		if (exp_ok)
		begin
			rd_exp("busy answer", 8'hFF, 8'hFF);
			if (drop)
			begin
				host.end_session(1'b0);
				chk("busy after port reset", 16'h0001, 16'(copy_busy));
			end
			k = 0;
			while (copy_busy !== 1'b0 && k < 80)
			begin
				@(posedge clk) #1;
				k++;
			end
			if (!drop)
				rd_exp("done answer", 8'h00, 8'hFF);
		end
		host.end_session(1'b0);
	endtask
	task automatic lock_run(input byte_t c);
		write_session(16'h0201, 1, 1'b0, c);
		copy_run(8'h01, 8'h02, 8'h01, 1'b1, 1'b0);
		chk("locks single copy", 16'h0000, 16'(control[2:0]));
		chk("crystal run", 16'(c[4]), 16'(crystal_run));
		copy_run(8'h01, 8'h02, 8'h81, 1'b1, 1'b0);
		copy_run(8'h01, 8'h02, 8'h81, 1'b1, 1'b0);
		chk("control locked", 16'(c), 16'(control));
	endtask
	task automatic line_to(input logic v, input int n);
		@(posedge clk) #1;
		line = v;
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic pulse_alarms(input logic [2:0] v);
		@(posedge clk) #1;
		{alarm_cyc, alarm_int, alarm_rtc} = v;
		@(posedge clk) #1;
		{alarm_cyc, alarm_int, alarm_rtc} = 3'h0;
		repeat (3) @(posedge clk);
		#1;
	endtask
	// ==========
	// main sequence
	initial
	begin
		rst_n = 1'b0;
		line = 1'b0;
		{alarm_cyc, alarm_int, alarm_rtc} = 3'h0;
		do_reset();
		chk("control reset", 16'h0000, 16'(control));
		chk("status reset", 16'h0000, 16'(end_status));
		foreach (rows[r])
		begin
			write_session(rows[r].a, rows[r].n, rows[r].p, rows[r].a[7:0]);
			chk("target addr", rows[r].a, target_addr);
			chk("end status", 16'(rows[r].es & rows[r].m), 16'(end_status & rows[r].m));
			read_check(rows[r].a, rows[r].es, rows[r].m);
		end
		pulse_alarms(3'h7);
		chk("expired no lock", 16'h0000, 16'(expired));
		write_session(16'h0026, 2, 1'b0, 8'h26);
		copy_run(8'h26, 8'h00, 8'h07, 1'b1, 1'b1);
		chk("copy count", 16'h0002, 16'(wr_n));
		chk("copy addr", 16'h0026, wr_a[0]);
		chk("copy addr", 16'h0027, wr_a[1]);
		chk("copy data", 16'(scr[7]), 16'(wr_d[1]));
		chk("auth flag", 16'h0087, 16'(end_status));
		write_session(16'h0026, 2, 1'b0, 8'h26);
		chk("auth cleared", 16'h0007, 16'(end_status));
		copy_run(8'h26, 8'h00, 8'h08, 1'b0, 1'b0);
		chk("no copy", 16'h0000, 16'(wr_n));
		chk("auth kept clear", 16'h0007, 16'(end_status));
		// auto mode with the long qualification delay of 40 cycles
		write_session(16'h0201, 1, 1'b0, 8'hB0);
		copy_run(8'h01, 8'h02, 8'h01, 1'b1, 1'b0);
		line_to(1'b1, 20);
		chk("timer line early", 16'h0000, 16'(timer_en));
		line_to(1'b1, 24);
		chk("timer line high", 16'h0001, 16'(timer_en));
		line_to(1'b0, 20);
		chk("cycle inc early", 16'h0000, 16'(inc_n));
		line_to(1'b0, 24);
		chk("cycle inc", 16'h0001, 16'(inc_n));
		chk("timer line low", 16'h0000, 16'(timer_en));
		lock_run(8'h1F);
		chk("timer manual", 16'h0001, 16'(timer_en));
		// short delay of 10 cycles now selected
		line_to(1'b1, 12);
		line_to(1'b0, 5);
		chk("cycle inc short early", 16'h0001, 16'(inc_n));
		line_to(1'b0, 7);
		chk("cycle inc short", 16'h0002, 16'(inc_n));
		write_session(16'h0201, 1, 1'b0, 8'h80);
		copy_run(8'h01, 8'h02, 8'h01, 1'b1, 1'b0);
		chk("guarded bits", 16'h008F, 16'(control));
		chk("crystal stop", 16'h0000, 16'(crystal_run));
		pulse_alarms(3'h1);
		chk("expired", 16'h0001, 16'(expired));
		chk("not rom only", 16'h0000, 16'(rom_only));
		write_session(16'h0300, 0, 1'b0, 8'h00);
		chk("write refused", 16'h0201, target_addr);
		read_check(16'h0201, 8'h81, 8'hFF);
		do_reset();
		lock_run(8'h17);
		pulse_alarms(3'h4);
		chk("rom only", 16'h0001, 16'(rom_only));
		host.start_cmd(8'hAA);
		host.read_byte(rb, rok);
		chk("read refused", 16'h0000, 16'(rok));
		host.end_session(1'b0);
		tally_and_finish();
	end
endmodule
